// [rtl/stfc_pkg.sv]
// package: constants and types shared by the serial transfer and fault control block
package stfc_pkg;
  localparam int         CR_IE     = 7;
  localparam int         CR_SPE    = 6;
  localparam int         CR_SPR2   = 5;
  localparam int         CR_MASTER_SELECT   = 4;
  localparam int         CR_CLOCK_POLARITY_SEL   = 3;
  localparam int         CR_CLOCK_PHASE_SEL   = 2;
  localparam int         CR_SPR1   = 1;
  localparam int         CR_SPR0   = 0;
  localparam int         SR_TRANSFER_DONE_FLAG   = 7;
  localparam int         SR_WRITE_COLLISION_FLAG   = 6;
  localparam int         SR_MODE_FAULT_FLAG   = 4;
  localparam logic [7:0] CR_RESET  = 8'h00;
  localparam logic [7:0] SR_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  // half serial clock periods in cpu clocks, per rate_select code
  localparam logic [6:0] HALF_D4   = 7'h02;
  localparam logic [6:0] HALF_D8   = 7'h04;
  localparam logic [6:0] HALF_D16  = 7'h08;
  localparam logic [6:0] HALF_D32  = 7'h10;
  localparam logic [6:0] HALF_D64  = 7'h20;
  localparam logic [6:0] HALF_D128 = 7'h40;
  typedef enum {MST_IDLE, MST_RUN} stfc_mst_e;
endpackage : stfc_pkg

// [rtl/stfc_link_if.sv]
// interface: signals between the cpu-side core and the serial-clock-side slave shifter
`timescale 1ns/1ps
interface stfc_link_if;
  logic       clock_polarity_sel;
  logic       clock_phase_sel;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       done_tgl;
  logic       start_tgl;
  logic       miso_bit;
  logic       launched;
  modport core (output clock_polarity_sel, clock_phase_sel, tx_byte, input rx_byte, done_tgl, start_tgl, miso_bit, launched);
  modport link (input clock_polarity_sel, clock_phase_sel, tx_byte, output rx_byte, done_tgl, start_tgl, miso_bit, launched);
endinterface : stfc_link_if

// [rtl/stfc_link.sv]
// slave shifter clocked by the incoming serial clock
`timescale 1ns/1ps
module stfc_link
  import stfc_pkg::*;
(
  input  wire logic rst_i,
  input  wire logic sck_i,
  input  wire logic ss_n_i,
  input  wire logic mosi_i,
  stfc_link_if.link lk
);
  // capture edge is always the rising edge of this derived clock
  wire        cap_clk = sck_i ^ (lk.clock_polarity_sel ^ lk.clock_phase_sel);
  logic [2:0] cnt;
  logic [7:0] rx;
  logic [2:0] lcnt;
  logic [7:0] sh;

  // select high ends the frame; the clock may stop with it
  always_ff @(posedge cap_clk or posedge ss_n_i) begin
    if (ss_n_i) begin
      cnt <= 3'h0;
      rx  <= BYTE_ZERO;
    end else begin
      rx  <= {rx[6:0], mosi_i};
      cnt <= cnt + 3'h1;
    end
  end

  always_ff @(posedge cap_clk or posedge rst_i) begin
    if (rst_i) begin
      lk.rx_byte  <= BYTE_ZERO;
      lk.done_tgl <= 1'b0;
    end else if (!ss_n_i && cnt == LAST_BIT) begin
      lk.rx_byte  <= {rx[6:0], mosi_i};
      lk.done_tgl <= ~lk.done_tgl;
    end
  end

  always_ff @(negedge cap_clk or posedge ss_n_i) begin
    if (ss_n_i) begin
      lcnt        <= 3'h0;
      sh          <= BYTE_ZERO;
      lk.miso_bit <= 1'b0;
      lk.launched <= 1'b0;
    end else begin
      lcnt        <= lcnt + 3'h1;
      lk.launched <= 1'b1;
      if (lcnt == 3'h0) begin
        // phase set: first edge presents the top bit; clear: top bit already out
        lk.miso_bit <= lk.clock_phase_sel ? lk.tx_byte[7] : lk.tx_byte[6];
        sh          <= lk.clock_phase_sel ? {lk.tx_byte[6:0], 1'b0} : {lk.tx_byte[5:0], 2'b00};
      end else begin
        lk.miso_bit <= sh[7];
        sh          <= {sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge cap_clk or posedge rst_i) begin
    if (rst_i) begin
      lk.start_tgl <= 1'b0;
    end else if (!ss_n_i && lk.clock_phase_sel && lcnt == 3'h0) begin
      lk.start_tgl <= ~lk.start_tgl;
    end
  end

  byte_done_a: assert property (@(posedge cap_clk) disable iff (ss_n_i || rst_i)
    cnt == LAST_BIT |=> lk.done_tgl != $past(lk.done_tgl))
    else $error("eighth capture did not complete the byte");
endmodule : stfc_link

// [rtl/stfc_core.sv]
// top: cpu-side control, status, data buffer, master engine and mode fault handling
`timescale 1ns/1ps
module stfc_core
  import stfc_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       halt_i,
  input  wire logic       wait_i,
  input  wire logic       cr_wr_i,
  input  wire logic [7:0] cr_wdata_i,
  input  wire logic       sr_acc_i,
  input  wire logic       dr_wr_i,
  input  wire logic [7:0] dr_wdata_i,
  input  wire logic       dr_rd_i,
  output logic      [7:0] control_reg_o,
  output logic      [7:0] status_reg_o,
  output logic      [7:0] data_buffer_reg_o,
  output logic            irq_o,
  output logic            wake_o,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o
);
  stfc_link_if lk ();

  stfc_link stfc_link_inst (
    .rst_i  (rst_i),
    .sck_i  (sck_i),
    .ss_n_i (ss_n_i),
    .mosi_i (mosi_i),
    .lk     (lk)
  );

  logic [7:0] ctrl;
  logic       transfer_done_flag;
  logic       write_collision_flag;
  logic       mode_fault_flag;
  logic       transfer_done_flag_arm;
  logic       write_collision_flag_arm;
  logic       mode_fault_flag_arm;
  logic [7:0] tx_byte;
  logic [7:0] rx_buf;
  logic       ss_s1;
  logic       ss_s2;
  logic       miso_s1;
  logic       miso_s2;
  logic       done_s1;
  logic       done_s2;
  logic       done_s3;
  logic       start_s1;
  logic       start_s2;
  stfc_mst_e  state;
  logic [6:0] div_cnt;
  logic [3:0] edge_cnt;
  logic [7:0] msh;
  logic       sck_q;
  logic       mosi_q;

  function automatic logic [6:0] half_period(input logic [2:0] rate_select);
    case (rate_select)
      3'h4:    half_period = HALF_D4;
      3'h0:    half_period = HALF_D8;
      3'h1:    half_period = HALF_D16;
      3'h6:    half_period = HALF_D32;
      3'h2:    half_period = HALF_D64;
      default: half_period = HALF_D128;
    endcase
  endfunction : half_period

  wire       run       = ~halt_i;
  wire       ss_low    = ~ss_s2;
  wire       slave_on  = ctrl[CR_SPE] & ~ctrl[CR_MASTER_SELECT];
  wire       master_on = ctrl[CR_SPE] & ctrl[CR_MASTER_SELECT];
  wire       clock_phase_sel      = ctrl[CR_CLOCK_PHASE_SEL];
  wire [6:0] half      = half_period({ctrl[CR_SPR2], ctrl[CR_SPR1], ctrl[CR_SPR0]});
  wire       busy_m    = state == MST_RUN;
  wire       tick      = busy_m & master_on & (div_cnt == half - 7'h01);
  // edge index even = leading edge of a bit
  wire       cap_edge  = edge_cnt[0] == clock_phase_sel;
  wire       m_done    = tick & (edge_cnt == LAST_EDGE);
  wire [7:0] m_rx      = cap_edge ? {msh[6:0], miso_s2} : msh;
  wire       s_done    = slave_on & (done_s2 ^ done_s3);
  wire       done_evt  = m_done | s_done;
  // slave lock: phase clear from low select, phase set from first edge to byte end
  wire       s_busy    = slave_on & (clock_phase_sel ? (start_s2 ^ done_s2) : ss_low);
  wire       collide   = dr_wr_i & (busy_m | s_busy);
  wire       dr_block  = transfer_done_flag & ~transfer_done_flag_arm;
  wire       dr_ok     = dr_wr_i & ~collide & ~dr_block;
  wire       m_start   = dr_ok & master_on & ~busy_m;
  wire       fault     = master_on & ss_low;
  wire       transfer_done_flag_clr  = transfer_done_flag_arm & dr_rd_i;
  wire       write_collision_flag_clr  = write_collision_flag_arm & (dr_rd_i | dr_wr_i);
  wire       mode_fault_flag_clr  = mode_fault_flag_arm & cr_wr_i;
  wire       irq_d     = ctrl[CR_IE] & (transfer_done_flag | mode_fault_flag);

  assign lk.clock_polarity_sel           = ctrl[CR_CLOCK_POLARITY_SEL];
  assign lk.clock_phase_sel           = clock_phase_sel;
  assign lk.tx_byte        = tx_byte;
  assign control_reg_o     = ctrl;
  assign data_buffer_reg_o = rx_buf;
  always_comb begin
    status_reg_o          = SR_RESET;
    status_reg_o[SR_TRANSFER_DONE_FLAG] = transfer_done_flag;
    status_reg_o[SR_WRITE_COLLISION_FLAG] = write_collision_flag;
    status_reg_o[SR_MODE_FAULT_FLAG] = mode_fault_flag;
  end

  // pin and cross-domain inputs; first stages feed only the second
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ss_s1    <= 1'b1;
      ss_s2    <= 1'b1;
      miso_s1  <= 1'b0;
      miso_s2  <= 1'b0;
      done_s1  <= 1'b0;
      done_s2  <= 1'b0;
      done_s3  <= 1'b0;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
    end else if (run) begin
      ss_s1    <= ss_n_i;
      ss_s2    <= ss_s1;
      miso_s1  <= miso_i;
      miso_s2  <= miso_s1;
      done_s1  <= lk.done_tgl;
      done_s2  <= done_s1;
      done_s3  <= done_s2;
      start_s1 <= lk.start_tgl;
      start_s2 <= start_s1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl <= CR_RESET;
    end else if (run) begin
      if (fault) begin
        ctrl[CR_SPE]  <= 1'b0;
        ctrl[CR_MASTER_SELECT] <= 1'b0;
      end else if (cr_wr_i) begin
        ctrl <= cr_wdata_i;
        if (mode_fault_flag && !mode_fault_flag_arm) begin
          // only the clearing write may raise enable or master
          ctrl[CR_SPE]  <= cr_wdata_i[CR_SPE] & ctrl[CR_SPE];
          ctrl[CR_MASTER_SELECT] <= cr_wdata_i[CR_MASTER_SELECT] & ctrl[CR_MASTER_SELECT];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_fault_flag     <= 1'b0;
      mode_fault_flag_arm <= 1'b0;
    end else if (run) begin
      if (fault) begin
        mode_fault_flag     <= 1'b1;
        mode_fault_flag_arm <= mode_fault_flag_arm & ~mode_fault_flag_clr;
      end else if (mode_fault_flag_clr) begin
        mode_fault_flag     <= 1'b0;
        mode_fault_flag_arm <= 1'b0;
      end else if (sr_acc_i && mode_fault_flag) begin
        mode_fault_flag_arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      transfer_done_flag     <= 1'b0;
      transfer_done_flag_arm <= 1'b0;
      rx_buf   <= BYTE_ZERO;
    end else if (run) begin
      if (done_evt) begin
        transfer_done_flag     <= 1'b1;
        transfer_done_flag_arm <= 1'b0;
        // an unacknowledged byte is kept; newer ones are dropped silently
        if (!transfer_done_flag || transfer_done_flag_clr) begin
          rx_buf <= m_done ? m_rx : lk.rx_byte;
        end
      end else if (transfer_done_flag_clr) begin
        transfer_done_flag     <= 1'b0;
        transfer_done_flag_arm <= 1'b0;
      end else if (sr_acc_i && transfer_done_flag) begin
        transfer_done_flag_arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      write_collision_flag     <= 1'b0;
      write_collision_flag_arm <= 1'b0;
    end else if (run) begin
      if (collide) begin
        write_collision_flag     <= 1'b1;
        write_collision_flag_arm <= write_collision_flag_arm & ~write_collision_flag_clr;
      end else if (write_collision_flag_clr) begin
        write_collision_flag     <= 1'b0;
        write_collision_flag_arm <= 1'b0;
      end else if (sr_acc_i && write_collision_flag) begin
        write_collision_flag_arm <= 1'b1;
      end
    end
  end

  // slave transmit byte; master bytes go straight into the shifter
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_byte <= BYTE_ZERO;
    end else if (run && dr_ok && !master_on) begin
      tx_byte <= dr_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state    <= MST_IDLE;
      div_cnt  <= 7'h00;
      edge_cnt <= 4'h0;
    end else if (run) begin
      case (state)
        MST_IDLE: begin
          div_cnt  <= 7'h00;
          edge_cnt <= 4'h0;
          if (m_start) begin
            state <= MST_RUN;
          end
        end
        MST_RUN: begin
          if (!master_on) begin
            state <= MST_IDLE;
          end else if (tick) begin
            div_cnt  <= 7'h00;
            edge_cnt <= edge_cnt + 4'h1;
            if (edge_cnt == LAST_EDGE) begin
              state <= MST_IDLE;
            end
          end else begin
            div_cnt <= div_cnt + 7'h01;
          end
        end
        default: state <= MST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
      msh    <= BYTE_ZERO;
    end else if (run) begin
      if (!busy_m) begin
        sck_q <= ctrl[CR_CLOCK_POLARITY_SEL];
        if (m_start) begin
          msh    <= dr_wdata_i;
          mosi_q <= dr_wdata_i[7];
        end
      end else if (tick) begin
        sck_q <= ~sck_q;
        if (cap_edge) begin
          msh <= {msh[6:0], miso_s2};
        end else begin
          mosi_q <= msh[7];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sck_o     <= 1'b0;
      sck_oe_o  <= 1'b0;
      mosi_o    <= 1'b0;
      mosi_oe_o <= 1'b0;
      irq_o     <= 1'b0;
      wake_o    <= 1'b0;
    end else if (run) begin
      sck_o     <= busy_m ? sck_q : ctrl[CR_CLOCK_POLARITY_SEL];
      sck_oe_o  <= master_on;
      mosi_o    <= mosi_q;
      mosi_oe_o <= master_on;
      irq_o     <= irq_d;
      wake_o    <= wait_i & irq_d;
    end else begin
      wake_o    <= 1'b0;
    end
  end

  // slave out must follow the external clock, so it is not retimed to mclk
  always_comb begin
    miso_o    = lk.launched ? lk.miso_bit : tx_byte[7];
    miso_oe_o = slave_on & ~ss_n_i & (~clock_phase_sel | lk.launched);
  end

  write_collision_flag_no_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && !transfer_done_flag && !mode_fault_flag && collide |=> !irq_o)
    else $error("write collision raised an interrupt");

  fault_drop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && fault |=> mode_fault_flag && !ctrl[CR_SPE] && !ctrl[CR_MASTER_SELECT])
    else $error("mode fault left enable or master set");

  fault_lock_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_fault_flag && !mode_fault_flag_arm && !ctrl[CR_SPE] |=> !ctrl[CR_SPE])
    else $error("enable set while mode fault pending");

  slave_no_mode_fault_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ctrl[CR_MASTER_SELECT] && !mode_fault_flag |=> !mode_fault_flag)
    else $error("mode fault set in slave role");

  write_collision_flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && collide |=> write_collision_flag)
    else $error("collision did not set flag");

  tx_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    collide |=> $stable(tx_byte) && (state == $past(state)) || !master_on)
    else $error("colliding write disturbed transfer");

  byte_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && m_done |=> state == MST_IDLE && transfer_done_flag)
    else $error("byte end did not set done flag");

  keep_first_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    transfer_done_flag && !transfer_done_flag_clr |=> $stable(rx_buf))
    else $error("unread byte overwritten");

  halt_freeze_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    halt_i |=> $stable(ctrl) && $stable(transfer_done_flag) && $stable(mode_fault_flag) && $stable(edge_cnt) && !wake_o)
    else $error("state changed in halt");

  irq_req_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && ctrl[CR_IE] && (transfer_done_flag || mode_fault_flag) |=> irq_o)
    else $error("pending event gave no request");

  sck_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    run && !busy_m ##1 run && !busy_m |=> sck_o == $past(ctrl[CR_CLOCK_POLARITY_SEL]))
    else $error("idle clock level wrong");
endmodule : stfc_core

// [sim/stfc_peer.sv]
// peer model: outside slave for master role, outside master for slave role
`timescale 1ns/1ps
module stfc_peer (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  output logic      miso_o
);
  logic [7:0] tx;
  logic [7:0] rx;
  logic       pol;
  logic       pha;
  int         idx;
  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    miso_o = 1'b0;
    pol    = 1'b0;
    pha    = 1'b0;
    idx    = -1;
  end
  task automatic load(input logic [7:0] b, input logic p, input logic h);
    tx     = b;
    pol    = p;
    pha    = h;
    idx    = h ? 7 : 6;
    miso_o = h ? ~miso_o : b[7];
  endtask : load
  // capture edge is rising when polarity equals phase
  always @(sck_i) begin
    if (sck_i ^ pol ^ pha) rx <= {rx[6:0], mosi_i};
    else if (idx >= 0) begin
      miso_o <= tx[idx];
      idx    <= idx - 1;
    end
    else miso_o <= ~miso_o;  // released line never keeps its last bit
  end
  // link clock runs only inside a frame
  task automatic send(input logic [7:0] b, input logic p, input logic h, output logic [7:0] got);
    got    = 8'h00;
    sck_o  = p;
    #16;
    ss_n_o = 1'b0;
    mosi_o = b[7];
    #16;
    for (int i = 7; i >= 0; i--) begin
      if (h) begin
        sck_o  = ~sck_o;
        mosi_o = b[i];
        #16;
      end
      sck_o = ~sck_o;
      got   = {got[6:0], miso_i};
      #16;
      if (!h) begin
        sck_o  = ~sck_o;
        mosi_o = (i > 0) ? b[i-1] : ~mosi_o;
        #16;
      end
    end
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #16;
  endtask : send
endmodule : stfc_peer

// [sim/stfc_core_tb.sv]
// testbench: cpu strobes, master and slave transfers, mode fault, power modes
`timescale 1ns/1ps
module stfc_core_tb
  import stfc_pkg::*;
;
  logic       mclk_i, rst_i, halt_i, wait_i, cr_wr_i, sr_acc_i, dr_wr_i, dr_rd_i;
  logic [7:0] cr_wdata_i, dr_wdata_i, control_reg_o, status_reg_o, data_buffer_reg_o;
  logic       irq_o, wake_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic       p_sck, p_ss_n, p_mosi, p_miso, done_q;
  logic [7:0] tx, sb, got;
  logic [7:0] exp_q[$];
  int         err_total, checks;

  stfc_core stfc_core_inst (.mclk_i(mclk_i), .rst_i(rst_i), .halt_i(halt_i), .wait_i(wait_i),
    .cr_wr_i(cr_wr_i), .cr_wdata_i(cr_wdata_i), .sr_acc_i(sr_acc_i), .dr_wr_i(dr_wr_i),
    .dr_wdata_i(dr_wdata_i), .dr_rd_i(dr_rd_i), .control_reg_o(control_reg_o),
    .status_reg_o(status_reg_o), .data_buffer_reg_o(data_buffer_reg_o), .irq_o(irq_o),
    .wake_o(wake_o), .sck_i(p_sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_n_i(p_ss_n),
    .mosi_i(p_mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(p_miso),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o));
  stfc_peer stfc_peer_inst (.sck_i(sck_o), .mosi_i(mosi_o), .miso_i(miso_o), .sck_o(p_sck),
    .ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso));

  always #50 mclk_i = ~mclk_i;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic settle();
    @(negedge mclk_i);
  endtask : settle
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge mclk_i);
    cr_wr_i    <= (k == 0);
    sr_acc_i   <= (k == 1);
    dr_wr_i    <= (k == 2);
    dr_rd_i    <= (k == 3);
    cr_wdata_i <= v;
    dr_wdata_i <= v;
    @(posedge mclk_i);
    {cr_wr_i, sr_acc_i, dr_wr_i, dr_rd_i} <= 4'h0;
  endtask : strobe
  task automatic sel(input logic v);
    @(posedge mclk_i);
    stfc_peer_inst.ss_n_o <= v;
    repeat (4) settle();
  endtask : sel
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (status_reg_o[b] !== 1'b1 && n < 2000) begin
      settle();
      n++;
    end
    if (n == 2000) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_flag

  // every rise of the done flag must bring the oldest expected byte
  always @(posedge mclk_i) begin
    done_q <= status_reg_o[SR_TRANSFER_DONE_FLAG];
    if (status_reg_o[SR_TRANSFER_DONE_FLAG] === 1'b1 && done_q === 1'b0) begin
      chk(8'(exp_q.size() > 0), 8'h01);
      if (exp_q.size() > 0) chk(data_buffer_reg_o, exp_q.pop_front());
    end
  end

  initial begin
    mclk_i = 1'b0;
    rst_i  = 1'b1;
    {halt_i, wait_i, cr_wr_i, sr_acc_i, dr_wr_i, dr_rd_i} = 6'h00;
    cr_wdata_i = 8'h00;
    dr_wdata_i = 8'h00;
    err_total  = 0;
    checks     = 0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    void'($urandom(5498));
    settle();
    chk(control_reg_o, CR_RESET);
    chk(status_reg_o, SR_RESET);
    chk({3'h0, sck_oe_o, mosi_oe_o, miso_oe_o, irq_o, wake_o}, 8'h00);
    $display("test reset finished");
    // master role, all four clock formats, rate /8
    for (int m = 0; m < 4; m++) begin
      tx = 8'($urandom);
      sb = 8'($urandom);
      strobe(0, {4'h5, m[1:0], 2'b00});
      repeat (4) settle();
      chk({7'h00, sck_o}, {7'h00, m[1]});
      stfc_peer_inst.load(sb, m[1], m[0]);
      exp_q.push_back(sb);
      strobe(2, tx);
      strobe(2, ~tx);
      wait_flag(SR_TRANSFER_DONE_FLAG);
      settle();
      chk(status_reg_o, 8'hc0);
      strobe(2, 8'h00);
      repeat (8) settle();
      chk(stfc_peer_inst.rx, tx);
      chk({7'h00, sck_o}, {7'h00, m[1]});
      strobe(1, 8'h00);
      strobe(3, 8'h00);
      settle();
      chk(status_reg_o, 8'h00);
    end
    $display("test master formats finished");
    strobe(0, 8'hd0);
    sel(1'b0);
    wait_flag(SR_MODE_FAULT_FLAG);
    settle();
    settle();
    chk(control_reg_o, 8'h80);
    chk({6'h00, irq_o, sck_oe_o | mosi_oe_o}, 8'h02);
    sel(1'b1);
    strobe(0, 8'hd0);
    settle();
    chk(control_reg_o, 8'h80);
    chk(status_reg_o, 8'h10);
    strobe(1, 8'h00);
    strobe(0, 8'h50);
    settle();
    settle();
    chk(status_reg_o, 8'h00);
    chk({control_reg_o[7:1], irq_o}, 8'h50);
    $display("test mode fault finished");
    // slave role, both phases, polarity follows phase
    for (int h = 0; h < 2; h++) begin
      tx = 8'($urandom);
      sb = 8'($urandom);
      strobe(0, {4'hc, h[0], h[0], 2'b00});
      sel(1'b0);
      chk({7'h00, miso_oe_o}, {7'h00, ~h[0]});
      strobe(2, tx);
      settle();
      chk(status_reg_o, h ? 8'h00 : 8'h40);
      chk({7'h00, irq_o}, 8'h00);
      sel(1'b1);
      if (h == 0) begin
        strobe(1, 8'h00);
        strobe(2, tx);
      end
      exp_q.push_back(sb);
      @(posedge mclk_i);
      #7;
      stfc_peer_inst.send(sb, h[0], h[0], got);
      wait_flag(SR_TRANSFER_DONE_FLAG);
      chk(got, tx);
      stfc_peer_inst.send(~sb, h[0], h[0], got);
      repeat (8) settle();
      chk(data_buffer_reg_o, sb);
      strobe(1, 8'h00);
      strobe(3, 8'h00);
      settle();
      chk(status_reg_o, 8'h00);
    end
    $display("test slave formats finished");
    @(posedge mclk_i);
    wait_i <= 1'b1;
    exp_q.push_back(8'h3c);
    @(posedge mclk_i);
    #7;
    stfc_peer_inst.send(8'h3c, 1'b1, 1'b1, got);
    wait_flag(SR_TRANSFER_DONE_FLAG);
    repeat (2) settle();
    chk({6'h00, irq_o, wake_o}, 8'h03);
    @(posedge mclk_i);
    halt_i <= 1'b1;
    strobe(1, 8'h00);
    strobe(3, 8'h00);
    repeat (2) settle();
    chk({status_reg_o[7:1], wake_o}, 8'h80);
    @(posedge mclk_i);
    halt_i <= 1'b0;
    wait_i <= 1'b0;
    strobe(1, 8'h00);
    strobe(3, 8'h00);
    repeat (2) settle();
    chk({status_reg_o[7:1], irq_o}, 8'h00);
    $display("test power modes finished");
    report_and_stop();
  end
endmodule : stfc_core_tb
